// >>> rtl/contactless_tx_coder_regs.svh
// register map, reset values, field positions and timing for the transmit coder
`ifndef CONTACTLESS_TX_CODER_REGS_SVH
`define CONTACTLESS_TX_CODER_REGS_SVH

// register addresses
`define ADDR_COMMAND 8'h01
`define ADDR_TX_DATA 8'h02
`define ADDR_LAST_BITS 8'h0f
`define ADDR_STATUS 8'h10
`define ADDR_MOD_SOURCE 8'h11
`define ADDR_CODER 8'h14
`define ADDR_PULSE_WIDTH 8'h15
`define ADDR_PRESET 8'h16
`define ADDR_TYPE_B 8'h17

// reset values
`define RST_CODER 8'h19
`define RST_PULSE_WIDTH 8'h13
`define RST_PRESET 8'h00
`define RST_TYPE_B 8'h3b
`define RST_MOD_SOURCE 2'h2
`define RST_LAST_BITS 3'h0

// fields
`define CODER_RATE 5:3
`define CODER_CODING 2:0
`define TB_NO_SOF 7
`define TB_NO_EOF 6
`define TB_EOF_LONG 5
`define TB_EGT 4:2
`define TB_SOF_SEL 1:0
`define SOF_SEL_LONG_LO 1
`define SOF_SEL_LONG_HI 0
`define CMD_START 0
`define LAST_BITS_F 2:0
`define MOD_SOURCE_F 6:5

// encodings
`define RATE_848 3'h0
`define RATE_424 3'h1
`define RATE_212 3'h2
`define RATE_106 3'h3
`define RATE_B 3'h4
`define CODING_NRZ_B 3'h0
`define MOD_LOW 2'h0
`define MOD_HIGH 2'h1
`define MOD_ENCODER 2'h2
`define MOD_PIN 2'h3

// frame element lengths in elementary time units
`define SOF_LO_SHORT 4'ha
`define SOF_LO_LONG 4'h b
`define SOF_HI_SHORT 4'h2
`define SOF_HI_LONG 4'h3
`define EOF_SHORT 4'ha
`define EOF_LONG 4'hb
`define A_SOF_UNITS 4'h1
`define A_EOF_UNITS 4'h2
`define CHAR_FULL_BITS 4'h8
`define B_FRAME_BITS 4'h2

// timing
`define CLK_PERIOD_NS 4
`define ETU_NS_848 1180
`define ETU_NS_424 2360
`define ETU_NS_212 4720
`define ETU_NS_106 9440
`define ETU_CYC_848 (`ETU_NS_848 / `CLK_PERIOD_NS)
`define ETU_CYC_424 (`ETU_NS_424 / `CLK_PERIOD_NS)
`define ETU_CYC_212 (`ETU_NS_212 / `CLK_PERIOD_NS)
`define ETU_CYC_106 (`ETU_NS_106 / `CLK_PERIOD_NS)

`endif

// >>> rtl/contactless_tx_coder_pkg.sv
// types shared by the transmit coder, its checker and the bench
package contactless_tx_coder_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    typedef struct packed {
        logic [2:0] rate;
        logic [2:0] coding;
        logic [7:0] pulse;
        logic no_sof;
        logic no_eof;
        logic eof_long;
        logic [2:0] egt;
        logic [1:0] sof_sel;
        logic [2:0] last_bits;
    } tx_cfg_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'b0_0001,
        S_SOF = 5'b0_0010,
        S_CHAR = 5'b0_0100,
        S_EGT = 5'b0_1000,
        S_EOF = 5'b1_0000
    } tx_state_t;

endpackage

// >>> rtl/tx_byte_fifo.sv
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ps
module tx_byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    wire wr_wrap = wr_ptr_ff == AW'(DEPTH - 1);
    wire rd_wrap = rd_ptr_ff == AW'(DEPTH - 1);

    assign in_ready = count_ff != CW'(DEPTH);
    assign out_valid = count_ff != '0;
    assign out_data = mem_ff[rd_ptr_ff];
    assign level = count_ff;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_wrap ? '0 : wr_ptr_ff + AW'(1);
            end
            if (pop) begin
                rd_ptr_ff <= rd_wrap ? '0 : rd_ptr_ff + AW'(1);
            end
            count_ff <= count_ff + CW'(push) - CW'(pop);
        end
    end
endmodule // tx_byte_fifo

// >>> rtl/contactless_tx_coder.sv
// transmit encoder of a contactless reader: miller (type a) and nrz (type b) framing
// Overview of operation
// - three-bit field selects encoder bit rate
// - coding field selects nrz/b or miller/a
// - pulse lasts two times (n plus 1) clocks
// - suppress bit omits type b start frame
// - suppress bit omits type b end frame
// - end frame lasts 11 or 10 units
// - guard time of 0..7 units between characters
// - start frame low/high lengths from two bits
// - coder control resets to 19h
// - pulse width register resets to 13h
// - type b framing register resets to 3bh
// - encoder reaches modulator only when source 10
// - send last-bits of final byte, then clear
`timescale 1ns/1ps
`include "contactless_tx_coder_regs.svh"
module contactless_tx_coder
    import contactless_tx_coder_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire bus_req_t bus_req,
    output logic [7:0] rdata,
    output logic fifo_ready,
    // modulator
    input wire logic ext_mod_pin,
    output logic mod_drive,
    output logic tx_busy
);
    localparam int LVW = 4;

    // register file
    logic [7:0] coder_ff;
    logic [7:0] pulse_ff;
    logic [7:0] preset_ff;
    logic [7:0] type_b_ff;
    logic [2:0] last_bits_ff;
    logic [1:0] mod_sel_ff;
    logic [7:0] rdata_ff;

    // frame engine
    tx_state_t state_ff;
    tx_state_t nxt_state;
    tx_cfg_t cfg_ff;
    logic [11:0] cyc_ff;
    logic [3:0] unit_ff;
    logic [7:0] byte_ff;
    logic [3:0] nbits_ff;
    logic last_ff;
    logic prev_ff;
    logic [9:0] pause_ff;
    logic enc_ff;
    logic mod_ff;
    logic pin_meta_ff;
    logic pin_sync_ff;
    logic load_char;
    logic frame_done;

    // fifo
    logic [7:0] fifo_data;
    logic fifo_valid;
    logic [LVW-1:0] fifo_level;

    // address decode
    wire hit_cmd = bus_req.addr == `ADDR_COMMAND;
    wire hit_data = bus_req.addr == `ADDR_TX_DATA;
    wire hit_last = bus_req.addr == `ADDR_LAST_BITS;
    wire hit_stat = bus_req.addr == `ADDR_STATUS;
    wire hit_mods = bus_req.addr == `ADDR_MOD_SOURCE;
    wire hit_coder = bus_req.addr == `ADDR_CODER;
    wire hit_pulse = bus_req.addr == `ADDR_PULSE_WIDTH;
    wire hit_preset = bus_req.addr == `ADDR_PRESET;
    wire hit_tb = bus_req.addr == `ADDR_TYPE_B;
    wire wr_last = bus_req.wr && hit_last;
    wire idle = state_ff == S_IDLE;

    // a start is ignored while a frame runs or the fifo holds nothing
    wire start_req = bus_req.wr && hit_cmd && bus_req.wdata[`CMD_START] && idle && fifo_valid;

    wire [7:0] status_val = {fifo_level, 2'h0, ~fifo_ready, tx_busy};
    wire [7:0] mods_val = {1'b0, mod_sel_ff, 5'h00};
    wire [7:0] last_val = {5'h00, last_bits_ff};
    wire [7:0] rd_mux =
        hit_coder ? coder_ff :
        hit_pulse ? pulse_ff :
        hit_preset ? preset_ff :
        hit_tb ? type_b_ff :
        hit_last ? last_val :
        hit_mods ? mods_val :
        hit_stat ? status_val : 8'h00;

    // live configuration, captured into cfg_ff when a frame starts
    wire live_b = coder_ff[`CODER_CODING] == `CODING_NRZ_B;
    wire live_no_sof = type_b_ff[`TB_NO_SOF];
    tx_cfg_t live_cfg;
    assign live_cfg.rate = coder_ff[`CODER_RATE];
    assign live_cfg.coding = coder_ff[`CODER_CODING];
    assign live_cfg.pulse = pulse_ff;
    assign live_cfg.no_sof = type_b_ff[`TB_NO_SOF];
    assign live_cfg.no_eof = type_b_ff[`TB_NO_EOF];
    assign live_cfg.eof_long = type_b_ff[`TB_EOF_LONG];
    assign live_cfg.egt = type_b_ff[`TB_EGT];
    assign live_cfg.sof_sel = type_b_ff[`TB_SOF_SEL];
    assign live_cfg.last_bits = last_bits_ff;

    // bit period per rate; reserved codes fall back to the slowest rate
    wire is_b = cfg_ff.coding == `CODING_NRZ_B;
    wire [11:0] etu_len =
        cfg_ff.rate == `RATE_848 ? 12'(`ETU_CYC_848) :
        cfg_ff.rate == `RATE_424 ? 12'(`ETU_CYC_424) :
        cfg_ff.rate == `RATE_212 ? 12'(`ETU_CYC_212) :
        12'(`ETU_CYC_106);
    wire tick = cyc_ff == etu_len - 12'h001;
    wire half = cyc_ff == {1'b0, etu_len[11:1]};
    wire bit_start = cyc_ff == 12'h000;

    // frame phase lengths: start frame, character, guard time, end frame
    wire [3:0] sof_lo = cfg_ff.sof_sel[`SOF_SEL_LONG_LO] ? `SOF_LO_LONG : `SOF_LO_SHORT;
    wire [3:0] sof_hi = cfg_ff.sof_sel[`SOF_SEL_LONG_HI] ? `SOF_HI_LONG : `SOF_HI_SHORT;
    wire [3:0] sof_len = is_b ? sof_lo + sof_hi : `A_SOF_UNITS;
    wire [3:0] eof_len = !is_b ? `A_EOF_UNITS : cfg_ff.eof_long ? `EOF_LONG : `EOF_SHORT;
    wire [3:0] char_len = is_b ? nbits_ff + `B_FRAME_BITS : nbits_ff;
    wire [3:0] egt_len = {1'b0, cfg_ff.egt};

    wire [3:0] phase_len =
        state_ff == S_SOF ? sof_len :
        state_ff == S_CHAR ? char_len :
        state_ff == S_EGT ? egt_len : eof_len;
    wire phase_end = tick && unit_ff == phase_len - 4'h1;

    // current data bit, lsb first; type b wraps it in start 0 and stop 1
    wire [3:0] bit_pos = is_b ? unit_ff - 4'h1 : unit_ff;
    wire data_bit = byte_ff[bit_pos[2:0]];
    wire b_char_bit = unit_ff == 4'h0 ? 1'b0 : unit_ff > nbits_ff ? 1'b1 : data_bit;
    wire cur_bit = is_b ? b_char_bit : data_bit;

    // nrz level for type b
    wire b_level =
        state_ff == S_SOF ? unit_ff >= sof_lo :
        state_ff == S_CHAR ? b_char_bit :
        state_ff == S_EOF ? 1'b0 : 1'b1;

    // modified miller pauses: a zero pauses at bit start unless after a one,
    // a one pauses at mid-bit; start frame pauses, end frame is zero then idle
    wire a_pause_start = !is_b && bit_start && (
        state_ff == S_SOF ||
        (state_ff == S_CHAR && !cur_bit && !prev_ff) ||
        (state_ff == S_EOF && unit_ff == 4'h0 && !prev_ff));
    wire a_pause_mid = !is_b && half && state_ff == S_CHAR && cur_bit;
    wire pause_go = a_pause_start || a_pause_mid;
    wire [9:0] pause_len = {1'b0, cfg_ff.pulse, 1'b0} + 10'h002;

    // short final byte only when last in fifo; a start without sof loads before the snapshot lands
    wire pop_last = fifo_level == LVW'(1);
    wire [2:0] load_bits = idle ? last_bits_ff : cfg_ff.last_bits;
    wire [3:0] pop_bits = pop_last && load_bits != 3'h0 ? {1'b0, load_bits} : `CHAR_FULL_BITS;
    wire enc_next = idle ? 1'b1 : is_b ? b_level : pause_ff == 10'h000 && !pause_go;

    // modulator source select
    wire mod_next =
        mod_sel_ff == `MOD_LOW ? 1'b0 :
        mod_sel_ff == `MOD_HIGH ? 1'b1 :
        mod_sel_ff == `MOD_ENCODER ? enc_ff : pin_sync_ff;

    assign rdata = rdata_ff;
    assign mod_drive = mod_ff;
    assign tx_busy = !idle;

    tx_byte_fifo #(
        .WIDTH(8),
        .DEPTH(8)
    ) u_fifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .in_valid(bus_req.wr && hit_data),
        .in_ready(fifo_ready),
        .in_data(bus_req.wdata),
        .out_valid(fifo_valid),
        .out_ready(load_char),
        .out_data(fifo_data),
        .level(fifo_level)
    );

    // frame sequencing
    always_comb begin
        nxt_state = state_ff;
        load_char = 1'b0;
        frame_done = 1'b0;
        case (state_ff)
            S_IDLE: begin
                if (start_req) begin
                    if (live_b && live_no_sof) begin
                        nxt_state = S_CHAR;
                        load_char = 1'b1;
                    end else begin
                        nxt_state = S_SOF;
                    end
                end
            end
            S_SOF: begin
                if (phase_end) begin
                    nxt_state = S_CHAR;
                    load_char = 1'b1;
                end
            end
            S_CHAR: begin
                if (phase_end) begin
                    if (last_ff) begin
                        if (is_b && cfg_ff.no_eof) begin
                            nxt_state = S_IDLE;
                            frame_done = 1'b1;
                        end else begin
                            nxt_state = S_EOF;
                        end
                    end else if (is_b && cfg_ff.egt != 3'h0) begin
                        nxt_state = S_EGT;
                    end else begin
                        nxt_state = S_CHAR;
                        load_char = 1'b1;
                    end
                end
            end
            S_EGT: begin
                if (phase_end) begin
                    nxt_state = S_CHAR;
                    load_char = 1'b1;
                end
            end
            S_EOF: begin
                if (phase_end) begin
                    nxt_state = S_IDLE;
                    frame_done = 1'b1;
                end
            end
            default: begin
                nxt_state = S_IDLE;
            end
        endcase
    end

    // register writes; reserved coder bits are stored as written
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            coder_ff <= `RST_CODER;
            pulse_ff <= `RST_PULSE_WIDTH;
            preset_ff <= `RST_PRESET;
            type_b_ff <= `RST_TYPE_B;
            mod_sel_ff <= `RST_MOD_SOURCE;
        end else if (bus_req.wr) begin
            if (hit_coder) begin
                coder_ff <= bus_req.wdata;
            end
            if (hit_pulse) begin
                pulse_ff <= bus_req.wdata;
            end
            if (hit_preset) begin
                preset_ff <= bus_req.wdata;
            end
            if (hit_tb) begin
                type_b_ff <= bus_req.wdata;
            end
            if (hit_mods) begin
                mod_sel_ff <= bus_req.wdata[`MOD_SOURCE_F];
            end
        end
    end

    // a software write in the frame's last cycle wins over the auto clear
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            last_bits_ff <= `RST_LAST_BITS;
        end else if (wr_last) begin
            last_bits_ff <= bus_req.wdata[`LAST_BITS_F];
        end else if (frame_done) begin
            last_bits_ff <= `RST_LAST_BITS;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_ff <= 8'h00;
        end else begin
            rdata_ff <= bus_req.rd ? rd_mux : 8'h00;
        end
    end

    // frame-wide snapshot keeps mid-frame writes from corrupting timing
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cfg_ff <= '0;
            state_ff <= S_IDLE;
        end else begin
            if (start_req) begin
                cfg_ff <= live_cfg;
            end
            state_ff <= nxt_state;
        end
    end

    // bit and unit timing
    always_ff @(posedge sys_clk) begin
        if (rst || idle || tick) begin
            cyc_ff <= 12'h000;
        end else begin
            cyc_ff <= cyc_ff + 12'h001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || idle || phase_end) begin
            unit_ff <= 4'h0;
        end else if (tick) begin
            unit_ff <= unit_ff + 4'h1;
        end
    end

    // character loader
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            byte_ff <= 8'h00;
            nbits_ff <= `CHAR_FULL_BITS;
            last_ff <= 1'b0;
        end else if (load_char) begin
            byte_ff <= fifo_data;
            nbits_ff <= pop_bits;
            last_ff <= pop_last;
        end
    end

    // miller history: start frame and end frame count as zeros
    always_ff @(posedge sys_clk) begin
        if (rst || idle) begin
            prev_ff <= 1'b0;
        end else if (tick) begin
            prev_ff <= state_ff == S_CHAR && cur_bit;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst || idle) begin
            pause_ff <= 10'h000;
        end else if (pause_go) begin
            pause_ff <= pause_len - 10'h001;
        end else if (pause_ff != 10'h000) begin
            pause_ff <= pause_ff - 10'h001;
        end
    end

    // output stage; the external pin is synchronised before use
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pin_meta_ff <= 1'b0;
            pin_sync_ff <= 1'b0;
            enc_ff <= 1'b1;
            mod_ff <= 1'b0;
        end else begin
            pin_meta_ff <= ext_mod_pin;
            pin_sync_ff <= pin_meta_ff;
            enc_ff <= enc_next;
            mod_ff <= mod_next;
        end
    end
endmodule // contactless_tx_coder

// >>> verification/card_model.sv
// passive card side: measures low and high run lengths of the modulator drive
`timescale 1ns/1ps
module card_model (
    // clock and measurement restart
    input wire logic sys_clk,
    input wire logic clr,
    // modulator drive as the field carries it
    input wire logic mod_drive
);
    logic [15:0] lo_len [8];
    logic [15:0] hi_len [8];
    logic [15:0] lo_min;
    logic [15:0] lo_max;
    logic [15:0] run = 16'h0001;
    logic prev = 1'h1;
    logic seen_lo = 1'h0;
    int n_lo = 0;
    int n_hi = 0;
    // a run is closed only at the level change, so a frame must end high to be complete
    always @(posedge sys_clk) begin
        if (clr) begin
            n_lo <= 0;
            n_hi <= 0;
            lo_min <= 16'hffff;
            lo_max <= 16'h0000;
            seen_lo <= 1'h0;
            prev <= mod_drive;
            run <= 16'h0001;
        end else if (mod_drive == prev) begin
            run <= run + 16'h0001;
        end else begin
            run <= 16'h0001;
            prev <= mod_drive;
            if (!prev) begin
                if (n_lo < 8) lo_len[n_lo] <= run;
                n_lo <= n_lo + 1;
                lo_min <= (run < lo_min) ? run : lo_min;
                lo_max <= (run > lo_max) ? run : lo_max;
                seen_lo <= 1'h1;
            end else if (seen_lo) begin
                if (n_hi < 8) hi_len[n_hi] <= run;
                n_hi <= n_hi + 1;
            end
        end
    end
endmodule // card_model

// >>> verification/tx_coder_checker.sv
// concurrent checks on the transmit coder ports
`timescale 1ns/1ps
`include "contactless_tx_coder_regs.svh"
module tx_coder_checker
    import contactless_tx_coder_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire bus_req_t bus_req,
    input wire logic [7:0] rdata,
    input wire logic fifo_ready,
    // modulator
    input wire logic ext_mod_pin,
    input wire logic mod_drive,
    input wire logic tx_busy
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0] coder_ff, width_ff, frame_ff, snap_width_ff;
    logic [1:0] src_ff;
    logic snap_a_ff;
    logic [15:0] low_run_ff;
    wire start_req = bus_req.wr && bus_req.addr == `ADDR_COMMAND && bus_req.wdata[`CMD_START] && !tx_busy;
    wire [7:0] nxt_coder = (bus_req.wr && bus_req.addr == `ADDR_CODER) ? bus_req.wdata : coder_ff;
    wire [7:0] nxt_width = (bus_req.wr && bus_req.addr == `ADDR_PULSE_WIDTH) ? bus_req.wdata : width_ff;
    wire [7:0] nxt_frame = (bus_req.wr && bus_req.addr == `ADDR_TYPE_B) ? bus_req.wdata : frame_ff;
    wire [1:0] nxt_src = (bus_req.wr && bus_req.addr == `ADDR_MOD_SOURCE) ? bus_req.wdata[6:5] : src_ff;
    wire [15:0] pulse_len = {7'h00, snap_width_ff, 1'h0} + 16'h0002;
    // snapshot at the start edge: mid-frame writes must not move the pulse width
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            coder_ff <= 8'h19;
            width_ff <= 8'h13;
            frame_ff <= 8'h3b;
            src_ff <= 2'h2;
            snap_width_ff <= 8'h13;
            snap_a_ff <= 1'h1;
            low_run_ff <= 16'h0000;
        end else begin
            coder_ff <= nxt_coder;
            width_ff <= nxt_width;
            frame_ff <= nxt_frame;
            src_ff <= nxt_src;
            snap_width_ff <= start_req ? width_ff : snap_width_ff;
            snap_a_ff <= start_req ? (coder_ff[2:0] != 3'h0) : snap_a_ff;
            low_run_ff <= mod_drive ? 16'h0000 : low_run_ff + 16'h0001;
        end
    end
    a_rdata_idle_zero:
        assert property (!$past(bus_req.rd) |-> rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_coder_readback:
        assert property (bus_req.rd && bus_req.addr == `ADDR_CODER |=> rdata == $past(coder_ff))
        else $error("coder register read back wrong");
    a_width_readback:
        assert property (bus_req.rd && bus_req.addr == `ADDR_PULSE_WIDTH |=> rdata == $past(width_ff))
        else $error("pulse width register read back wrong");
    a_frame_readback:
        assert property (bus_req.rd && bus_req.addr == `ADDR_TYPE_B |=> rdata == $past(frame_ff))
        else $error("frame setup register read back wrong");
    a_unmapped_zero:
        assert property (bus_req.rd && bus_req.addr > `ADDR_TYPE_B |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    a_status_bits:
        assert property (bus_req.rd && bus_req.addr == `ADDR_STATUS |=> rdata[1:0] == {!$past(fifo_ready), $past(tx_busy)})
        else $error("status full or busy bit wrong");
    a_busy_needs_start:
        assert property ($rose(tx_busy) |-> $past(start_req))
        else $error("busy rose without a start");
    a_source_low:
        assert property ((src_ff == `MOD_LOW) [*4] |-> !mod_drive)
        else $error("modulator not low for low source");
    a_source_high:
        assert property ((src_ff == `MOD_HIGH) [*4] |-> mod_drive)
        else $error("modulator not high for high source");
    a_source_pin:
        assert property ((src_ff == `MOD_PIN && $stable(ext_mod_pin)) [*6] |-> mod_drive == ext_mod_pin)
        else $error("modulator does not follow the pin");
    a_idle_carrier:
        assert property ((!tx_busy && src_ff == `MOD_ENCODER) [*4] |-> mod_drive)
        else $error("idle encoder source modulates");
    a_pulse_width:
        assert property ($rose(mod_drive) && tx_busy && snap_a_ff && src_ff == `MOD_ENCODER |-> low_run_ff == pulse_len)
        else $error("type a pause length wrong");
    c_type_a_frame: cover property ($rose(tx_busy) && snap_a_ff);
    c_type_b_frame: cover property ($rose(tx_busy) && !snap_a_ff);
    c_fifo_full: cover property (!fifo_ready);
    c_pin_source: cover property (src_ff == `MOD_PIN && mod_drive);
endmodule // tx_coder_checker

bind contactless_tx_coder tx_coder_checker u_checker (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
    .rdata(rdata), .fifo_ready(fifo_ready), .ext_mod_pin(ext_mod_pin), .mod_drive(mod_drive), .tx_busy(tx_busy));

// >>> verification/tb_top.sv
// self-checking bench: registers, modulator source, type a and type b frame timing
`timescale 1ns/1ps
`include "contactless_tx_coder_regs.svh"
module tb_top
    import contactless_tx_coder_pkg::*;
;
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    bus_req_t bus_req = '0;
    logic ext_mod_pin = 1'h0;
    logic clr = 1'h0;
    logic [7:0] rdata;
    logic fifo_ready;
    logic mod_drive;
    logic tx_busy;
    logic [7:0] cfg;
    logic [15:0] etu;
    int nb;
    int n_errors = 0;
    int comparisons = 0;
    logic [7:0] rst_addr [8] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h0f, 8'h11, 8'h10, 8'h30};
    logic [7:0] rst_val [8] = '{8'h19, 8'h13, 8'h00, 8'h3b, 8'h00, 8'h40, 8'h00, 8'h00};
    logic [1:0] src_tab [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
    logic mod_exp [5] = '{1'h0, 1'h1, 1'h1, 1'h0, 1'h1};

    always #2 sys_clk = ~sys_clk;

    contactless_tx_coder DUT (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
        .fifo_ready(fifo_ready), .ext_mod_pin(ext_mod_pin), .mod_drive(mod_drive), .tx_busy(tx_busy));
    card_model card (.sys_clk(sys_clk), .clr(clr), .mod_drive(mod_drive));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR at %0t: %s got %0h expected %0h", $time, what, got, exp);
        end
    endtask

    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge sys_clk);
        bus_req <= '{addr: addr, wdata: data, wr: 1'h1, rd: 1'h0};
        @(posedge sys_clk);
        bus_req <= '0;
    endtask

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp, input string what);
        @(posedge sys_clk);
        bus_req <= '{addr: addr, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge sys_clk);
        bus_req <= '0;
        #1 chk({8'h00, rdata}, {8'h00, exp}, what);
    endtask

    // restart the card's measurement, start the frame and wait for its end
    task automatic run_frame(input logic mid_write);
        int k = 0;
        @(posedge sys_clk);
        clr <= 1'h1;
        @(posedge sys_clk);
        clr <= 1'h0;
        wr_reg(`ADDR_COMMAND, 8'h01);
        @(posedge sys_clk);
        #1 chk({15'h0000, tx_busy}, 16'h0001, "busy after start");
        if (mid_write) wr_reg(`ADDR_PULSE_WIDTH, 8'h09);
        while (tx_busy !== 1'h0 && k < 40000) begin
            @(posedge sys_clk);
            #1 k++;
        end
        chk({15'h0000, tx_busy}, 16'h0000, "frame end");
        repeat (6) @(posedge sys_clk);
    endtask

    task automatic summarize();
        $display("comparisons %0d n_errors %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // the frames below need roughly 88k cycles
    initial begin
        repeat (95000) @(posedge sys_clk);
        n_errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        summarize();
    end

    initial begin
        repeat (12) @(posedge sys_clk);
        rst <= 1'h0;
        for (int i = 0; i < 8; i++) rd_chk(rst_addr[i], rst_val[i], "reset value");
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            @(posedge sys_clk);
            ext_mod_pin <= (i == 4);
            wr_reg(`ADDR_MOD_SOURCE, {1'h0, src_tab[i], 5'h00});
            repeat (6) @(posedge sys_clk);
            #1 chk({15'h0000, mod_drive}, {15'h0000, mod_exp[i]}, "modulator source");
        end
        wr_reg(`ADDR_MOD_SOURCE, 8'h40);
        $display("test modulator source done");
        for (int r = 1; r < 4; r++) begin
            etu = 16'h0127 << r;
            wr_reg(`ADDR_CODER, {2'h0, 3'(r), 3'h1});
            wr_reg(`ADDR_PULSE_WIDTH, 8'h04);
            wr_reg(`ADDR_LAST_BITS, 8'h02);
            wr_reg(`ADDR_TX_DATA, 8'h07);
            run_frame(1'h1);
            chk(16'(card.n_lo), 16'h0003, "pauses with two final bits");
            chk(card.lo_min, 16'h000a, "shortest pause");
            chk(card.lo_max, 16'h000a, "longest pause");
            chk(card.hi_len[0], etu + (etu >> 1) - 16'h000a, "first one bit position");
            rd_chk(`ADDR_LAST_BITS, 8'h00, "final bit count cleared");
        end
        $display("test type a rates done");
        wr_reg(`ADDR_CODER, 8'h01);
        wr_reg(`ADDR_PULSE_WIDTH, 8'h04);
        for (int i = 0; i < 9; i++) wr_reg(`ADDR_TX_DATA, (i == 8) ? 8'h55 : 8'h00);
        #1 chk({15'h0000, fifo_ready}, 16'h0000, "full fifo refuses");
        rd_chk(`ADDR_STATUS, 8'h82, "status when full");
        run_frame(1'h0);
        chk(16'(card.n_lo), 16'h0042, "pauses of eight zero bytes");
        chk(card.lo_max, 16'h000a, "pause width");
        rd_chk(`ADDR_STATUS, 8'h00, "status when drained");
        $display("test fifo fill and drain done");
        wr_reg(`ADDR_CODER, 8'h00);
        for (int i = 0; i < 5; i++) begin
            cfg = (i == 4) ? 8'hc0 : {2'h0, 1'(i), 3'(2 * i), 2'(i)};
            nb = (i == 3) ? 2 : 1;
            wr_reg(`ADDR_TYPE_B, cfg);
            rd_chk(`ADDR_TYPE_B, cfg, "frame setup readback");
            for (int b = 0; b < nb; b++) wr_reg(`ADDR_TX_DATA, 8'hff);
            run_frame(1'h0);
            if (i == 4) begin
                chk(16'(card.n_lo), 16'h0001, "lows with both marks suppressed");
                chk(card.lo_len[0], 16'h0127, "start bit");
            end else begin
                chk(card.lo_len[0], 16'h0127 * (i > 1 ? 16'h000b : 16'h000a), "start mark low");
                chk(card.hi_len[0], 16'h0127 * (i[0] ? 16'h0003 : 16'h0002), "start mark high");
                chk(card.lo_len[1], 16'h0127, "start bit");
                chk(card.lo_len[nb + 1], 16'h0127 * (i[0] ? 16'h000b : 16'h000a), "end mark");
                chk(16'(card.n_lo), 16'(nb + 2), "low phases in frame");
                if (nb == 2) chk(card.hi_len[1], 16'h0127 * 16'h000f, "guard time");
            end
        end
        $display("test type b framing done");
        summarize();
    end
endmodule // tb_top
